// ==== pkg/swb_pkg.sv ====
// Constants and types for the subtract-with-borrow datapath and its bus slave
package swb_pkg;
   // Datapath widths
   localparam int DATA_W = 8;
   localparam int NIBBLE_W = 4;
   localparam int IDX_W = 4;
   localparam int MEM_DEPTH = 16;

   // Register byte offsets inside the slave window
   localparam logic [7:0] OFF_ACC = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_EXEC = 8'h08;
   localparam logic [7:0] OFF_MEM_BASE = 8'h40;
   localparam int MEM_IDX_LSB = 2;
   localparam int MEM_REGION_LSB = 6;

   // Status field positions
   localparam int STAT_C_BIT = 0;
   localparam int STAT_DC_BIT = 1;
   localparam int STAT_Z_BIT = 2;

   // Execute command field positions
   localparam int EXEC_IDX_LSB = 0;
   localparam int EXEC_DEST_BIT = 8;

   // Destination select encodings
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // Reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] MEM_RESET = 8'h00;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // AHB-Lite encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // Bus slave phases, Gray coded along idle, read wait, read done
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RWAIT = 2'h1,
      ST_RDONE = 2'h3,
      ST_WDATA = 2'h2
   } swb_bus_state_type;
endpackage

// ==== pkg/swb_alu_if.sv ====
// Operand and result bundle between the core and the subtract-with-borrow unit
`timescale 1ns/1ns
`default_nettype none
interface swb_alu_if
   import swb_pkg::*;
   ;
   logic [DATA_W-1:0] operand;
   logic [DATA_W-1:0] accum;
   logic carry_in;
   logic [DATA_W-1:0] result;
   logic carry_out;
   logic dc_out;
   logic zero_out;

   modport core (output operand, output accum, output carry_in,
      input result, input carry_out, input dc_out, input zero_out);
   modport alu (input operand, input accum, input carry_in,
      output result, output carry_out, output dc_out, output zero_out);
endinterface
`default_nettype wire

// ==== core/swb_alu.sv ====
// Combinational subtract-with-borrow unit: operand minus accumulator minus not-carry
`timescale 1ns/1ns
`default_nettype none
module swb_alu
   import swb_pkg::*;
(
   swb_alu_if.alu alu
);
   logic [DATA_W:0] full_diff;
   logic [NIBBLE_W:0] low_diff;

   // Extra bit on top catches the borrow out of each width
   assign full_diff = {1'b0, alu.operand} - {1'b0, alu.accum}
      - {{DATA_W{1'b0}}, ~alu.carry_in};
   assign low_diff = {1'b0, alu.operand[NIBBLE_W-1:0]} - {1'b0, alu.accum[NIBBLE_W-1:0]}
      - {{NIBBLE_W{1'b0}}, ~alu.carry_in};

   // Carry and digit carry read as not-borrow
   assign alu.result = full_diff[DATA_W-1:0];
   assign alu.carry_out = ~full_diff[DATA_W];
   assign alu.dc_out = ~low_diff[NIBBLE_W];
   assign alu.zero_out = (full_diff[DATA_W-1:0] == 8'h00);
endmodule
`default_nettype wire

// ==== core/swb_top.sv ====
// AHB-Lite reachable accumulator, flag and file store around the subtract-with-borrow unit
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module swb_top
   import swb_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   // Bus slave state
   swb_bus_state_type state_q;
   swb_bus_state_type state_d;
   logic [7:0] addr_q;
   logic word_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;

   // Architectural state
   logic [DATA_W-1:0] acc_q;
   logic [DATA_W-1:0] mem_q [MEM_DEPTH];
   logic c_q;
   logic dc_q;
   logic z_q;
   logic [IDX_W-1:0] cmd_idx_q;
   logic cmd_dest_q;

   // Decode wires
   logic accept;
   logic wr_phase;
   logic hit_acc;
   logic hit_status;
   logic hit_exec;
   logic hit_mem;
   logic [IDX_W-1:0] mem_addr_idx;
   logic wr_acc;
   logic wr_status;
   logic wr_mem;
   logic exec_fire;
   logic [IDX_W-1:0] exec_idx;
   logic exec_dest;
   logic [31:0] rd_sel;
   logic [31:0] status_word;
   logic [31:0] exec_word;

   swb_alu_if alu_bus ();

   swb_alu u_alu (
      .alu(alu_bus.alu)
   );

   // Address phase is taken only when the bus is ready and the transfer is real
   assign accept = HSEL && HTRANS[1] && HREADY;
   assign wr_phase = (state_q == ST_WDATA) && word_q;

   // Register decode on the latched address
   assign hit_acc = (addr_q == OFF_ACC);
   assign hit_status = (addr_q == OFF_STATUS);
   assign hit_exec = (addr_q == OFF_EXEC);
   assign hit_mem = (addr_q[7:MEM_REGION_LSB] == OFF_MEM_BASE[7:MEM_REGION_LSB])
      && (addr_q[MEM_IDX_LSB-1:0] == 2'h0);
   assign mem_addr_idx = addr_q[MEM_IDX_LSB +: IDX_W];

   // Write strobes; sub-word writes are dropped so a byte store cannot half-load a register
   assign wr_acc = wr_phase && hit_acc;
   assign wr_status = wr_phase && hit_status;
   assign wr_mem = wr_phase && hit_mem;
   assign exec_fire = wr_phase && hit_exec;
   assign exec_idx = HWDATA[EXEC_IDX_LSB +: IDX_W];
   assign exec_dest = HWDATA[EXEC_DEST_BIT];

   // Operands come straight from the store, so a command sees the previous write's effect
   assign alu_bus.operand = mem_q[exec_idx];
   assign alu_bus.accum = acc_q;
   assign alu_bus.carry_in = c_q;

   // Read data selection
   assign status_word = {29'h0000_0000, z_q, dc_q, c_q};
   assign exec_word = {23'h00_0000, cmd_dest_q, 4'h0, cmd_idx_q};
   assign rd_sel = hit_acc ? {24'h00_0000, acc_q} :
      hit_status ? status_word :
      hit_exec ? exec_word :
      hit_mem ? {24'h00_0000, mem_q[mem_addr_idx]} :
      32'h0000_0000;

   // Next phase: reads take one wait state so read data always reflects the last write
   assign state_d = (state_q == ST_RWAIT) ? ST_RDONE :
      accept ? (HWRITE ? ST_WDATA : ST_RWAIT) :
      ST_IDLE;

   // Bus phase tracking and address latch
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         addr_q <= 8'h00;
         word_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (accept) begin
            addr_q <= HADDR[7:0];
            word_q <= (HSIZE == HSIZE_WORD);
         end
      end
   end

   // Bus outputs, all registered
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         hrdata_q <= RDATA_RESET;
         hreadyout_q <= 1'b1;
         hresp_q <= HRESP_OKAY;
      end else begin
         hreadyout_q <= !(accept && !HWRITE);
         hresp_q <= HRESP_OKAY;
         if (state_q == ST_RWAIT) begin
            hrdata_q <= rd_sel;
         end
      end
   end

   assign HRDATA = hrdata_q;
   assign HREADYOUT = hreadyout_q;
   assign HRESP = hresp_q;

   // Accumulator: direct write or result with destination 0
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         acc_q <= ACC_RESET;
      end else if (wr_acc) begin
         acc_q <= HWDATA[DATA_W-1:0];
      end else if (exec_fire && exec_dest == DEST_ACC) begin
         acc_q <= alu_bus.result;
      end
   end

   // Flags: direct status write presets them, execution replaces all three
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         c_q <= FLAG_RESET;
         dc_q <= FLAG_RESET;
         z_q <= FLAG_RESET;
      end else if (wr_status) begin
         c_q <= HWDATA[STAT_C_BIT];
         dc_q <= HWDATA[STAT_DC_BIT];
         z_q <= HWDATA[STAT_Z_BIT];
      end else if (exec_fire) begin
         c_q <= alu_bus.carry_out;
         dc_q <= alu_bus.dc_out;
         z_q <= alu_bus.zero_out;
      end
   end

   // Last command, kept so software can see what ran
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cmd_idx_q <= 4'h0;
         cmd_dest_q <= DEST_ACC;
      end else if (exec_fire) begin
         cmd_idx_q <= exec_idx;
         cmd_dest_q <= exec_dest;
      end
   end

   // File store, one flop group per entry
   for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_file
      logic bus_wr;
      logic res_wr;
      assign bus_wr = wr_mem && (mem_addr_idx == IDX_W'(i));
      assign res_wr = exec_fire && (exec_dest == DEST_FILE) && (exec_idx == IDX_W'(i));
      always_ff @(posedge CLOCK or negedge RST_N) begin
         if (!RST_N) begin
            mem_q[i] <= MEM_RESET;
         end else if (bus_wr) begin
            mem_q[i] <= HWDATA[DATA_W-1:0];
         end else if (res_wr) begin
            mem_q[i] <= alu_bus.result;
         end
      end
   end

   // Checks on the datapath and the read wait state; result, carry and zero against an independent reference
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   logic [DATA_W:0] ref_full;
   logic [DATA_W-1:0] ref_plain;
   assign ref_full = {1'b0, alu_bus.operand} - {1'b0, alu_bus.accum}
      - {8'h00, ~c_q};
   assign ref_plain = alu_bus.operand - alu_bus.accum;

   sequence exec_acc_s;
      exec_fire && (exec_dest == DEST_ACC);
   endsequence

   sequence exec_file_s;
      exec_fire && (exec_dest == DEST_FILE);
   endsequence

   result_value_a: assert property (
      exec_fire |-> alu_bus.result == ref_full[DATA_W-1:0])
      else $error("subtract result differs from operand minus accumulator minus not-carry");

   carry_term_a: assert property (
      exec_fire |-> (c_q ? alu_bus.result == ref_plain
         : alu_bus.result == ref_plain - 8'h01))
      else $error("carry term not applied as inverted carry");

   flags_update_a: assert property (
      exec_fire |=> c_q == $past(alu_bus.carry_out) && dc_q == $past(alu_bus.dc_out)
         && z_q == $past(alu_bus.zero_out))
      else $error("flags not updated by execution");

   flags_hold_a: assert property (
      !exec_fire && !wr_status |=> $stable({c_q, dc_q, z_q}))
      else $error("flags changed without execution or status write");

   acc_dest_a: assert property (
      exec_acc_s |=> acc_q == $past(ref_full[DATA_W-1:0])
         && mem_q[$past(exec_idx)] == $past(alu_bus.operand))
      else $error("destination 0 did not load accumulator only");

   file_dest_a: assert property (
      exec_file_s |=> mem_q[$past(exec_idx)] == $past(ref_full[DATA_W-1:0])
         && $stable(acc_q))
      else $error("destination 1 did not write back to file register");

   carry_zero_a: assert property (
      exec_fire |-> alu_bus.carry_out == !ref_full[DATA_W]
         && alu_bus.zero_out == (ref_full[DATA_W-1:0] == 8'h00))
      else $error("carry or zero flag rule violated");

   read_wait_a: assert property (
      accept && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read did not take exactly one wait state");
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the subtract-with-borrow datapath over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import swb_pkg::*;
;
   logic clock;
   logic rst_n;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   int error_cnt = 0;
   int checked = 0;
   logic [7:0] m_acc;
   logic [2:0] m_stat;
   logic [7:0] m_file [MEM_DEPTH];

   // Single slave, so its ready output closes the loop as the bus ready
   swb_top dut_u (.CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));

   // Free running 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Bounded wait for ready sampled high at a rising edge; a hang ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask

   // One single transfer: address phase, then data phase, read data at its closing edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      hsize <= sz;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check("hresp", {31'h00000000, hresp}, {31'h00000000, HRESP_OKAY});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, HSIZE_WORD, d, r);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, HSIZE_WORD, 32'h00000000, r);
      check(name, r, exp);
   endtask

   function automatic logic [7:0] faddr(input int i);
      return OFF_MEM_BASE + 8'(i << MEM_IDX_LSB);
   endfunction

   // Async reset held ten cycles; the model restarts from the reset values
   task automatic apply_reset();
      rst_n <= 1'b0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      m_acc = ACC_RESET;
      m_stat = 3'h0;
      foreach (m_file[k]) m_file[k] = MEM_RESET;
   endtask

   // Preset operands; DC and Z start set so a stale flag shows up
   task automatic setup(input int i, input logic [7:0] f, input logic [7:0] a, input logic c);
      m_file[i] = f;
      m_acc = a;
      m_stat = {2'b11, c};
      wr(faddr(i), {24'h000000, f});
      wr(OFF_ACC, {24'h000000, a});
      wr(OFF_STATUS, {29'h00000000, m_stat});
   endtask

   // Expected result worked out with a nine-bit borrow chain
   task automatic do_exec(input int i, input logic d);
      logic [8:0] full;
      logic [4:0] low;
      logic c_term;
      c_term = ~m_stat[STAT_C_BIT];
      full = {1'b0, m_file[i]} - {1'b0, m_acc} - 9'(c_term);
      low = {1'b0, m_file[i][3:0]} - {1'b0, m_acc[3:0]} - 5'(c_term);
      m_stat = {full[7:0] == 8'h00, ~low[4], ~full[8]};
      if (d == DEST_ACC) begin
         m_acc = full[7:0];
      end else begin
         m_file[i] = full[7:0];
      end
      wr(OFF_EXEC, (32'(d) << EXEC_DEST_BIT) | 32'(i));
      rd_chk("acc", OFF_ACC, {24'h000000, m_acc});
      rd_chk("file", faddr(i), {24'h000000, m_file[i]});
      rd_chk("other file", faddr(i ^ 1), {24'h000000, m_file[i ^ 1]});
      rd_chk("status", OFF_STATUS, {29'h00000000, m_stat});
      rd_chk("exec", OFF_EXEC, {23'h000000, d, 4'h0, 4'(i)});
   endtask

   task automatic t_reset();
      rd_chk("acc rst", OFF_ACC, {24'h000000, ACC_RESET});
      rd_chk("status rst", OFF_STATUS, 32'h00000000);
      rd_chk("exec rst", OFF_EXEC, 32'h00000000);
      rd_chk("file0 rst", faddr(0), {24'h000000, MEM_RESET});
      rd_chk("file15 rst", faddr(15), {24'h000000, MEM_RESET});
   endtask

   // The three worked cases with the result sent back to the file
   task automatic t_examples();
      setup(3, 8'h33, 8'h01, 1'b1);
      do_exec(3, DEST_FILE);
      check("ex1", {24'h000000, m_file[3]}, 32'h00000032);
      rd_chk("ex1 file", faddr(3), 32'h00000032);
      rd_chk("ex1 flags", OFF_STATUS, 32'h00000003);
      setup(3, 8'h02, 8'h01, 1'b0);
      do_exec(3, DEST_FILE);
      rd_chk("ex2 file", faddr(3), 32'h00000000);
      rd_chk("ex2 flags", OFF_STATUS, 32'h00000007);
      setup(4, 8'h04, 8'h05, 1'b0);
      do_exec(4, DEST_FILE);
      check("ex3", {24'h000000, m_file[4]}, 32'h000000FE);
      rd_chk("ex3 file", faddr(4), 32'h000000FE);
      rd_chk("ex3 flags", OFF_STATUS, 32'h00000000);
   endtask

   // Both destinations and both carry values across borrow boundaries
   task automatic t_matrix();
      logic [15:0] pairs [5];
      pairs = '{16'h0000, 16'h00FF, 16'h1001, 16'h807F, 16'hFFFF};
      for (int d = 0; d < 2; d++) begin
         for (int c = 0; c < 2; c++) begin
            foreach (pairs[p]) begin
               setup(p + 6, pairs[p][15:8], pairs[p][7:0], 1'(c));
               do_exec(p + 6, 1'(d));
            end
         end
      end
   endtask

   // Back to back executions feed on the flags and result just produced
   task automatic t_chain();
      setup(15, 8'h10, 8'h08, 1'b1);
      do_exec(15, DEST_ACC);
      do_exec(15, DEST_ACC);
      do_exec(15, DEST_FILE);
      do_exec(15, DEST_FILE);
   endtask

   // Unmapped writes and non-word writes must leave everything alone
   task automatic t_refuse();
      logic [31:0] r;
      wr(8'h3C, 32'hFFFFFFFF);
      rd_chk("unmapped", 8'h3C, 32'h00000000);
      bus(1'b1, OFF_ACC, 3'h0, 32'h000000A5, r);
      rd_chk("byte write", OFF_ACC, {24'h000000, m_acc});
   endtask

   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h00000000;
      apply_reset();
      t_reset();
      t_examples();
      t_matrix();
      t_chain();
      t_refuse();
      apply_reset();
      t_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
